/* core/pmcd_pkg.sv */
package pmcd_pkg;

  // Register byte addresses
  localparam logic [31:0] PMCD_PREKEY_ADDR  = 32'hFFFF_0404;
  localparam logic [31:0] PMCD_CTRL_ADDR    = 32'hFFFF_0408;
  localparam logic [31:0] PMCD_POSTKEY_ADDR = 32'hFFFF_040C;
  localparam logic [31:0] PMCD_STATUS_ADDR  = 32'hFFFF_0480;

  // Key values
  localparam logic [31:0] PMCD_PREKEY_VALUE  = 32'h0000_0001;
  localparam logic [31:0] PMCD_POSTKEY_VALUE = 32'h0000_00F4;

  // Control register layout and reset value
  localparam logic [7:0]  PMCD_CTRL_RESET = 8'h79;
  localparam int unsigned PMCD_PREC_BIT   = 7;
  localparam int unsigned PMCD_XTAL_BIT   = 6;
  localparam int unsigned PMCD_PLL_BIT    = 5;
  localparam int unsigned PMCD_PERIPH_BIT = 4;
  localparam int unsigned PMCD_CORE_BIT   = 3;
  localparam int unsigned PMCD_DIV_LSB    = 0;
  localparam int unsigned PMCD_DIV_W      = 3;
  localparam logic [7:0]  PMCD_WAKE_MASK  = 8'h38;

  // Status register layout
  localparam int unsigned PMCD_STAT_PREC_BIT    = 0;
  localparam int unsigned PMCD_STAT_XTAL_BIT    = 1;
  localparam int unsigned PMCD_STAT_PLL_BIT     = 2;
  localparam int unsigned PMCD_STAT_PERIPH_BIT  = 3;
  localparam int unsigned PMCD_STAT_CORE_BIT    = 4;
  localparam int unsigned PMCD_STAT_ARMED_BIT   = 5;
  localparam int unsigned PMCD_STAT_PENDING_BIT = 6;
  localparam int unsigned PMCD_STAT_WAKEPIN_BIT = 7;

  // Peripheral domains: sram, flash, gpio, spi, uart
  localparam int unsigned PMCD_PERIPH_DOMAINS = 5;

  // Bus responses
  localparam logic [1:0] PMCD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PMCD_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PMCD_KEY_IDLE,
    PMCD_KEY_ARMED,
    PMCD_KEY_PENDING
  } pmcd_key_t;

endpackage

/* core/pmcd_core_div.sv */
`timescale 1ns/100ps
module pmcd_core_div
  import pmcd_pkg::*;
#(
  parameter int unsigned DIV_W = PMCD_DIV_W
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             pll_tick,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divide,
  output logic                  core_tick
);

  localparam int unsigned CNT_W = (1 << DIV_W) - 1;

  if (DIV_W < 1 || DIV_W > 4) begin : g_check
    $error("pmcd_core_div: DIV_W must be 1 to 4");
  end

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] terminal;
  logic             tick_reg;
  logic             tick_next;

  // Divide PLL ticks by two to the power of the code
  always_comb begin
    terminal  = CNT_W'((1 << divide) - 1);
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!run) begin
      cnt_next = '0;
    end else if (pll_tick) begin
      if (cnt_reg >= terminal) begin
        cnt_next  = '0;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign core_tick = tick_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  tick_from_pll_a: assert property (core_tick |-> $past(pll_tick) && $past(run))
    else $error("core tick without a PLL tick");
  full_rate_a: assert property (run && pll_tick && divide == '0 && $past(run) |=> core_tick)
    else $error("code zero must pass every PLL tick");

endmodule

/* core/pmcd_top.sv */
// Behaviour
// - Bit 7 clear powers down precision input
// - Bit 6 clear powers down crystal circuitry
// - Bit 5 clear powers down the PLL
// - PLL off only with core and peripherals
// - Peripherals off only with core in same write
// - Bit 3 clear powers down the core
// - PLL, peripheral and core enables set at reset and on wake
// - Core clock is PLL over two-power code
// - PLL-clocked timers stop with the PLL
// - Peripheral power-down covers five interface domains
// - LIN wake works with peripherals down
// - Wake-up timer runs on low-power oscillator
// - Control write needs pre and post keys
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module pmcd_top
  import pmcd_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           reset,
  input  wire logic [31:0]                    s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [31:0]                    s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  input  wire logic                           high_voltage_config,
  input  wire logic                           pll_tick,
  input  wire logic                           wake_pin,
  input  wire logic                           lin_wake,
  input  wire logic                           wakeup_timer_wake,
  input  wire logic                           wakeup_timer_lp_sel,
  output logic                                precision_osc_en,
  output logic                                xtal_en,
  output logic                                pll_en,
  output logic                                periph_en,
  output logic [PMCD_PERIPH_DOMAINS-1:0]      periph_domain_en,
  output logic                                core_en,
  output logic                                core_clk_tick,
  output logic                                pll_timer_tick,
  output logic                                wakeup_timer_run
);

  // Bus write side
  logic        aw_hold_reg;
  logic        aw_hold_next;
  logic [31:0] aw_addr_reg;
  logic [31:0] aw_addr_next;
  logic        w_hold_reg;
  logic        w_hold_next;
  logic [31:0] w_data_reg;
  logic [31:0] w_data_next;
  logic [3:0]  w_strb_reg;
  logic [3:0]  w_strb_next;
  logic        bvalid_reg;
  logic        bvalid_next;
  logic [1:0]  bresp_reg;
  logic [1:0]  bresp_next;
  logic        do_write;
  logic        wr_mapped;

  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign do_write      = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_mapped     = aw_addr_reg == PMCD_PREKEY_ADDR || aw_addr_reg == PMCD_CTRL_ADDR ||
                         aw_addr_reg == PMCD_POSTKEY_ADDR || aw_addr_reg == PMCD_STATUS_ADDR;

  always_comb begin
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next  = w_hold_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (do_write) begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_mapped ? PMCD_RESP_OKAY : PMCD_RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 32'h0000_0000;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= PMCD_RESP_OKAY;
    end else begin
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg  <= w_hold_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // Wake pin synchroniser and filter
  logic [2:0] wake_sync_reg;
  logic [2:0] wake_sync_next;
  logic       wake_level_reg;
  logic       wake_level_next;
  logic       wake_pin_event;
  logic       wake_event;

  always_comb begin
    wake_sync_next  = {wake_sync_reg[1:0], wake_pin};
    wake_level_next = wake_level_reg;
    if (wake_sync_reg[1] == wake_sync_reg[2]) begin
      wake_level_next = wake_sync_reg[2];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake_sync_reg  <= 3'h0;
      wake_level_reg <= 1'b0;
    end else begin
      wake_sync_reg  <= wake_sync_next;
      wake_level_reg <= wake_level_next;
    end
  end

  assign wake_pin_event = wake_sync_reg[1] && wake_sync_reg[2] && !wake_level_reg;
  // LIN and wake-up timer wakes do not depend on the peripheral enable
  assign wake_event = wake_pin_event || lin_wake || wakeup_timer_wake;

  // Key sequence and control register
  pmcd_key_t  key_reg;
  pmcd_key_t  key_next;
  logic [7:0] pend_data_reg;
  logic [7:0] pend_data_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic       full_word;
  logic       is_prekey;
  logic       is_postkey;
  logic       is_ctrl_wr;
  logic       commit;
  logic [7:0] legal;

  assign full_word  = w_strb_reg == 4'hF;
  assign is_prekey  = aw_addr_reg == PMCD_PREKEY_ADDR && full_word && w_data_reg == PMCD_PREKEY_VALUE;
  assign is_postkey = aw_addr_reg == PMCD_POSTKEY_ADDR && full_word && w_data_reg == PMCD_POSTKEY_VALUE;
  assign is_ctrl_wr = aw_addr_reg == PMCD_CTRL_ADDR && w_strb_reg[0];
  assign commit     = do_write && key_reg == PMCD_KEY_PENDING && is_postkey;

  always_comb begin
    key_next       = key_reg;
    pend_data_next = pend_data_reg;
    if (do_write) begin
      case (key_reg)
        PMCD_KEY_IDLE: begin
          key_next = is_prekey ? PMCD_KEY_ARMED : PMCD_KEY_IDLE;
        end
        PMCD_KEY_ARMED: begin
          if (is_ctrl_wr) begin
            key_next       = PMCD_KEY_PENDING;
            pend_data_next = w_data_reg[7:0];
          end else begin
            key_next = is_prekey ? PMCD_KEY_ARMED : PMCD_KEY_IDLE;
          end
        end
        PMCD_KEY_PENDING: begin
          key_next = is_prekey ? PMCD_KEY_ARMED : PMCD_KEY_IDLE;
        end
        default: begin
          key_next = PMCD_KEY_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    legal                  = pend_data_reg;
    legal[PMCD_PERIPH_BIT] = pend_data_reg[PMCD_PERIPH_BIT] || pend_data_reg[PMCD_CORE_BIT];
    legal[PMCD_PLL_BIT]    = pend_data_reg[PMCD_PLL_BIT] || legal[PMCD_PERIPH_BIT];
    ctrl_next              = ctrl_reg;
    if (commit) begin
      ctrl_next = legal;
    end
    if (wake_event) begin
      ctrl_next = ctrl_next | PMCD_WAKE_MASK;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      key_reg       <= PMCD_KEY_IDLE;
      pend_data_reg <= 8'h00;
      ctrl_reg      <= PMCD_CTRL_RESET;
    end else begin
      key_reg       <= key_next;
      pend_data_reg <= pend_data_next;
      ctrl_reg      <= ctrl_next;
    end
  end

  // Power and clock outputs
  logic prec_reg;
  logic prec_next;
  logic timer_tick_reg;
  logic timer_tick_next;
  logic wt_run_reg;
  logic wt_run_next;

  always_comb begin
    prec_next       = ctrl_reg[PMCD_PREC_BIT] && high_voltage_config;
    timer_tick_next = pll_tick && ctrl_reg[PMCD_PLL_BIT];
    wt_run_next     = wakeup_timer_lp_sel || ctrl_reg[PMCD_PERIPH_BIT];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prec_reg       <= 1'b0;
      timer_tick_reg <= 1'b0;
      wt_run_reg     <= 1'b0;
    end else begin
      prec_reg       <= prec_next;
      timer_tick_reg <= timer_tick_next;
      wt_run_reg     <= wt_run_next;
    end
  end

  assign precision_osc_en = prec_reg;
  assign xtal_en          = ctrl_reg[PMCD_XTAL_BIT];
  assign pll_en           = ctrl_reg[PMCD_PLL_BIT];
  assign periph_en        = ctrl_reg[PMCD_PERIPH_BIT];
  assign periph_domain_en = {PMCD_PERIPH_DOMAINS{ctrl_reg[PMCD_PERIPH_BIT]}};
  assign core_en          = ctrl_reg[PMCD_CORE_BIT];
  assign pll_timer_tick   = timer_tick_reg;
  assign wakeup_timer_run = wt_run_reg;

  pmcd_core_div #(
    .DIV_W (PMCD_DIV_W)
  ) u_div (
    .clk       (clk),
    .reset     (reset),
    .pll_tick  (pll_tick),
    .run       (ctrl_reg[PMCD_PLL_BIT] && ctrl_reg[PMCD_CORE_BIT]),
    .divide    (ctrl_reg[PMCD_DIV_LSB +: PMCD_DIV_W]),
    .core_tick (core_clk_tick)
  );

  // Bus read side
  logic        rvalid_reg;
  logic        rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0]  rresp_reg;
  logic [1:0]  rresp_next;
  logic [7:0]  status;

  assign s_axi_arready = !rvalid_reg;

  always_comb begin
    status                        = 8'h00;
    status[PMCD_STAT_PREC_BIT]    = prec_reg;
    status[PMCD_STAT_XTAL_BIT]    = ctrl_reg[PMCD_XTAL_BIT];
    status[PMCD_STAT_PLL_BIT]     = ctrl_reg[PMCD_PLL_BIT];
    status[PMCD_STAT_PERIPH_BIT]  = ctrl_reg[PMCD_PERIPH_BIT];
    status[PMCD_STAT_CORE_BIT]    = ctrl_reg[PMCD_CORE_BIT];
    status[PMCD_STAT_ARMED_BIT]   = key_reg == PMCD_KEY_ARMED;
    status[PMCD_STAT_PENDING_BIT] = key_reg == PMCD_KEY_PENDING;
    status[PMCD_STAT_WAKEPIN_BIT] = wake_level_reg;
    rvalid_next                   = rvalid_reg;
    rdata_next                    = rdata_reg;
    rresp_next                    = rresp_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = PMCD_RESP_OKAY;
      case (s_axi_araddr)
        PMCD_CTRL_ADDR:    rdata_next = {24'h00_0000, ctrl_reg};
        PMCD_STATUS_ADDR:  rdata_next = {24'h00_0000, status};
        PMCD_PREKEY_ADDR:  rdata_next = 32'h0000_0000;
        PMCD_POSTKEY_ADDR: rdata_next = 32'h0000_0000;
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = PMCD_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= PMCD_RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  prec_gate_a: assert property (!high_voltage_config || !ctrl_reg[PMCD_PREC_BIT] |=> !precision_osc_en)
    else $error("precision input enabled without both enables");
  xtal_off_a: assert property (commit && !pend_data_reg[PMCD_XTAL_BIT] && !wake_event |=> !xtal_en)
    else $error("crystal not powered down by keyed write");
  pll_order_a: assert property (!pll_en |-> !core_en && !periph_en)
    else $error("PLL off while core or peripherals on");
  periph_order_a: assert property (!periph_en |-> !core_en && periph_domain_en == '0)
    else $error("peripherals off while core on");
  core_off_a: assert property (commit && !pend_data_reg[PMCD_CORE_BIT] && !wake_event |=> !core_en)
    else $error("core not powered down by keyed write");
  wake_set_a: assert property (wake_event |=> core_en && periph_en && pll_en)
    else $error("wake did not restore enables");
  lin_wake_a: assert property (lin_wake && !periph_en |=> periph_en && core_en)
    else $error("LIN wake lost while peripherals down");
  timer_stop_a: assert property (!pll_en |=> !pll_timer_tick)
    else $error("PLL timer tick while PLL down");
  wt_run_a: assert property (wakeup_timer_lp_sel |=> wakeup_timer_run)
    else $error("wake-up timer stopped on low-power clock");
  key_guard_a: assert property ($changed(ctrl_reg) |-> $past(commit) || $past(wake_event))
    else $error("control changed without key sequence");
  reserved_zero_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == PMCD_CTRL_ADDR
                                    |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000)
    else $error("reserved control bits not zero");

  commit_c: cover property (commit);
  wake_c: cover property (!core_en ##1 wake_event ##1 core_en);
  slow_div_c: cover property (core_clk_tick && ctrl_reg[2:0] == 3'h7);
  key_abort_c: cover property (do_write && key_reg == PMCD_KEY_PENDING && !is_postkey);

endmodule

/* bench/test_power_mode_clock_divider.sv */
`timescale 1ns/100ps
module test_power_mode_clock_divider
  import pmcd_pkg::*;
();
  typedef struct packed {
    logic [31:0] wv;
    logic        hv;
    logic        lp;
    logic [7:0]  ex;
  } pmcd_row_t;

  logic        clk = 1'b0;
  logic        reset;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        high_voltage_config, wake_pin, lin_wake, wakeup_timer_wake, wakeup_timer_lp_sel;
  logic        pll_tick = 1'b0;
  logic        precision_osc_en, xtal_en, pll_en, periph_en, core_en;
  logic        core_clk_tick, pll_timer_tick, wakeup_timer_run;
  logic [PMCD_PERIPH_DOMAINS-1:0] periph_domain_en;
  int          fails = 0;
  int          checked = 0;
  int          pl_cnt = 0;
  int          pt_cnt = 0;
  int          ct_cnt = 0;

  pmcd_row_t rows [7] = '{
    '{32'h0000_00FF, 1'b1, 1'b0, 8'hFF},
    '{32'hFFFF_FFC2, 1'b0, 1'b0, 8'hC2},
    '{32'h0000_0010, 1'b1, 1'b1, 8'h30},
    '{32'h0000_0008, 1'b1, 1'b0, 8'h38},
    '{32'h0000_0020, 1'b0, 1'b1, 8'h20},
    '{32'h0000_0079, 1'b1, 1'b0, 8'h79},
    '{32'h0000_0000, 1'b1, 1'b0, 8'h00}
  };

  pmcd_top dut_u (.clk(clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .high_voltage_config(high_voltage_config),
    .pll_tick(pll_tick), .wake_pin(wake_pin), .lin_wake(lin_wake), .wakeup_timer_wake(wakeup_timer_wake),
    .wakeup_timer_lp_sel(wakeup_timer_lp_sel), .precision_osc_en(precision_osc_en), .xtal_en(xtal_en),
    .pll_en(pll_en), .periph_en(periph_en), .periph_domain_en(periph_domain_en), .core_en(core_en),
    .core_clk_tick(core_clk_tick), .pll_timer_tick(pll_timer_tick), .wakeup_timer_run(wakeup_timer_run));

  always #4 clk = ~clk;

  // PLL output pulse every other cycle and tick counters
  always @(posedge clk) begin
    pll_tick <= ~pll_tick;
    if (pll_tick) pl_cnt <= pl_cnt + 1;
    if (pll_timer_tick) pt_cnt <= pt_cnt + 1;
    if (core_clk_tick) ct_cnt <= ct_cnt + 1;
  end

  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tmo();
    fails++;
    summarize();
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    bit ea, ew, hs;
    hs = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 200 && !hs; n++) begin
      @(negedge clk);
      ea = s_axi_awvalid && s_axi_awready;
      ew = s_axi_wvalid && s_axi_wready;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        hs = 1;
      end
      @(posedge clk);
      if (ea) s_axi_awvalid <= 1'b0;
      if (ew) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!hs) tmo();
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ea, hs;
    hs = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 200 && !hs; n++) begin
      @(negedge clk);
      ea = s_axi_arvalid && s_axi_arready;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        hs = 1;
      end
      @(posedge clk);
      if (ea) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!hs) tmo();
  endtask

  task automatic kw(input logic [31:0] v);
    logic [1:0] r;
    wr(PMCD_PREKEY_ADDR, PMCD_PREKEY_VALUE, 4'hF, r);
    wr(PMCD_CTRL_ADDR, v, 4'hF, r);
    wr(PMCD_POSTKEY_ADDR, PMCD_POSTKEY_VALUE, 4'hF, r);
  endtask

  // Waits for the next core tick and returns the PLL tick count at that point
  task automatic nt(output int p);
    int c0;
    bit hs;
    c0 = ct_cnt;
    hs = 0;
    for (int n = 0; n < 600 && !hs; n++) begin
      @(negedge clk);
      hs = (ct_cnt != c0);
    end
    p = pl_cnt;
    if (!hs) tmo();
  endtask

  task automatic do_reset();
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk);
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd(PMCD_CTRL_ADDR, d, r);
    chk("reset ctrl", d, 32'h0000_0079);
    chk("reset resp", 32'(r), 32'(PMCD_RESP_OKAY));
    chk("reset en", {27'h0, precision_osc_en, xtal_en, pll_en, periph_en, core_en}, 32'h0000_000F);
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  e;
    int          a, b, c, p0, c0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {high_voltage_config, wake_pin, lin_wake, wakeup_timer_wake, wakeup_timer_lp_sel} = '0;
    reset = 1'b1;
    do_reset();
    foreach (rows[i]) begin
      @(posedge clk);
      high_voltage_config <= rows[i].hv;
      wakeup_timer_lp_sel <= rows[i].lp;
      kw(rows[i].wv);
      e = rows[i].ex;
      repeat (3) @(posedge clk);
      rd(PMCD_CTRL_ADDR, d, r);
      chk("ctrl", d, {24'h0, e});
      rd(PMCD_STATUS_ADDR, d, r);
      chk("status", d, {27'h0, e[3], e[4], e[5], e[6], e[7] & rows[i].hv});
      chk("en", {27'h0, precision_osc_en, xtal_en, pll_en, periph_en, core_en},
          {27'h0, e[7] & rows[i].hv, e[6], e[5], e[4], e[3]});
      chk("domain", 32'(periph_domain_en), {27'h0, {5{e[4]}}});
      chk("wtimer", 32'(wakeup_timer_run), 32'(rows[i].lp | e[4]));
      p0 = pt_cnt;
      c0 = ct_cnt;
      repeat (20) @(posedge clk);
      chk("ptimer", 32'(pt_cnt - p0), e[5] ? 32'h0000_000A : 32'h0000_0000);
      if (!(e[5] && e[3])) chk("ctick", 32'(ct_cnt - c0), 32'h0000_0000);
    end
    for (int k = 0; k < 8; k++) begin
      kw(32'h0000_0078 | 32'(k));
      nt(a);
      nt(b);
      nt(c);
      chk("div", 32'(c - b), 32'(1 << k));
    end
    for (int k = 0; k < 3; k++) begin
      kw(32'h0000_0000);
      @(posedge clk);
      lin_wake <= (k == 0);
      wakeup_timer_wake <= (k == 1);
      wake_pin <= (k == 2);
      @(posedge clk);
      lin_wake <= 1'b0;
      wakeup_timer_wake <= 1'b0;
      repeat (10) @(posedge clk);
      rd(PMCD_STATUS_ADDR, d, r);
      chk("wake level", 32'(d[PMCD_STAT_WAKEPIN_BIT]), 32'(k == 2));
      wake_pin <= 1'b0;
      repeat (6) @(posedge clk);
      rd(PMCD_CTRL_ADDR, d, r);
      chk("wake", d, 32'h0000_0038);
    end
    wr(PMCD_CTRL_ADDR, 32'h0000_0000, 4'hF, r);
    chk("bare resp", 32'(r), 32'(PMCD_RESP_OKAY));
    wr(PMCD_PREKEY_ADDR, PMCD_PREKEY_VALUE, 4'hF, r);
    wr(PMCD_CTRL_ADDR, 32'h0000_0000, 4'hF, r);
    wr(PMCD_STATUS_ADDR, 32'h0000_0000, 4'hF, r);
    wr(PMCD_POSTKEY_ADDR, PMCD_POSTKEY_VALUE, 4'hF, r);
    wr(PMCD_PREKEY_ADDR, PMCD_PREKEY_VALUE, 4'hF, r);
    wr(PMCD_CTRL_ADDR, 32'h0000_0000, 4'hF, r);
    wr(PMCD_POSTKEY_ADDR, 32'h0000_00F5, 4'hF, r);
    rd(PMCD_CTRL_ADDR, d, r);
    chk("broken key", d, 32'h0000_0038);
    wr(PMCD_PREKEY_ADDR, PMCD_PREKEY_VALUE, 4'hF, r);
    rd(PMCD_STATUS_ADDR, d, r);
    chk("armed", 32'(d[PMCD_STAT_ARMED_BIT]), 32'h0000_0001);
    wr(PMCD_CTRL_ADDR, 32'h0000_0010, 4'hF, r);
    rd(PMCD_STATUS_ADDR, d, r);
    chk("pending", 32'(d[PMCD_STAT_PENDING_BIT]), 32'h0000_0001);
    wr(PMCD_POSTKEY_ADDR, PMCD_POSTKEY_VALUE, 4'hF, r);
    rd(PMCD_CTRL_ADDR, d, r);
    chk("read in key", d, 32'h0000_0030);
    wr(32'hFFFF_0500, 32'h0000_0000, 4'hF, r);
    chk("unmapped wr", 32'(r), 32'(PMCD_RESP_SLVERR));
    rd(32'hFFFF_0500, d, r);
    chk("unmapped rd", {d[29:0], r}, {30'h0, PMCD_RESP_SLVERR});
    do_reset();
    summarize();
  end
endmodule
